// >>> pixel_port_pkg.sv
// Purpose: Shared constants and types of the pixel port multiplexer.
// Assumes: 32-bit AHB-Lite register access, byte addresses below.
// Notes: Format codes are the low six bits of the format-select register.
package pixel_port_pkg;

   // Register byte offsets
   localparam int ADDR_BITS = 12;
   localparam logic [11:0] OFF_FORMAT = 12'h000;
   localparam logic [11:0] OFF_CONTROL = 12'h004;
   localparam logic [11:0] OFF_PAGE = 12'h008;
   localparam logic [11:0] OFF_STATUS = 12'h00c;

   // Reset values
   localparam logic [7:0] FORMAT_RESET = 8'h2d;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] PAGE_RESET = 8'h00;

   // Field positions
   localparam int FORMAT_CODE_BITS = 6;
   localparam int NIBBLE_ENABLE_BIT = 3;
   localparam int SPLIT_SHIFT_BIT = 2;
   localparam int STATUS_MODE_POS = 0;
   localparam int STATUS_REMAIN_POS = 8;
   localparam int STATUS_INDEX_POS = 16;

   // Format codes
   localparam logic [5:0] CODE_PASS = 6'h2d;
   localparam logic [3:0] CODE_PLANE1 = 4'h4;
   localparam logic [3:0] CODE_PLANE2 = 4'h5;
   localparam logic [3:0] CODE_PLANE4 = 4'h6;
   localparam logic [3:0] CODE_PLANE8 = 4'h7;
   localparam logic [5:0] CODE_NIBBLE = 6'h1f;

   // Bus and pin widths
   localparam int PIXEL_BUS_BITS = 32;
   localparam int LEGACY_BITS = 8;
   localparam int NIBBLE_BUS_BITS = 16;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef enum logic [2:0] {
      MODE_PASS,
      MODE_PLANE1,
      MODE_PLANE2,
      MODE_PLANE4,
      MODE_PLANE8,
      MODE_NIBBLE,
      MODE_RESERVED
   } mode_type;

   typedef struct packed {
      mode_type mode;
      logic [5:0] per_load;
   } decode_type;

endpackage

// >>> ahb_register_port.sv
// Purpose: AHB-Lite slave holding the format, control and page registers.
// Assumes: Single word transfers; zero wait states; response always OKAY.
// Notes: Read data forwards a write completing in the same cycle.
`timescale 1ns/10ps
module ahb_register_port
   import pixel_port_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic [7:0] format_reg,
   output logic [7:0] control_reg,
   output logic [7:0] page_reg,
   input wire logic [31:0] status
);

   typedef struct packed {
      logic wr_pend;
      logic [11:0] wr_addr;
      logic [7:0] format;
      logic [7:0] control;
      logic [7:0] page;
      logic [31:0] rdata;
   } reg_state_type;

   reg_state_type q;
   reg_state_type d;

   always_comb begin
      d = q;
      d.wr_pend = 1'b0;
      if (q.wr_pend) begin
         if (q.wr_addr == OFF_FORMAT) begin
            d.format = hwdata[7:0];
         end else if (q.wr_addr == OFF_CONTROL) begin
            d.control = hwdata[7:0];
         end else if (q.wr_addr == OFF_PAGE) begin
            d.page = hwdata[7:0];
         end
      end
      if (hsel && hready && htrans[1] && hsize == HSIZE_WORD) begin
         if (hwrite) begin
            d.wr_pend = 1'b1;
            d.wr_addr = haddr[ADDR_BITS-1:0];
         end else if (haddr[ADDR_BITS-1:0] == OFF_FORMAT) begin
            d.rdata = {24'h00_0000, d.format};
         end else if (haddr[ADDR_BITS-1:0] == OFF_CONTROL) begin
            d.rdata = {24'h00_0000, d.control};
         end else if (haddr[ADDR_BITS-1:0] == OFF_PAGE) begin
            d.rdata = {24'h00_0000, d.page};
         end else if (haddr[ADDR_BITS-1:0] == OFF_STATUS) begin
            d.rdata = status;
         end else begin
            d.rdata = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q.wr_pend <= 1'b0;
         q.wr_addr <= 12'h000;
         q.format <= FORMAT_RESET;
         q.control <= CONTROL_RESET;
         q.page <= PAGE_RESET;
         q.rdata <= 32'h0000_0000;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         q <= d;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   assign hrdata = q.rdata;
   assign format_reg = q.format;
   assign control_reg = q.control;
   assign page_reg = q.page;

endmodule // ahb_register_port

// >>> pixel_port_multiplexer.sv
// Purpose: Pixel port input multiplexer feeding the colour palette address.
// Assumes: Bus-load and dot clocks are slow pins sampled by hclk.
// Notes: One bus load is latched per bus-load clock rise, then shifted
//        out one group per dot clock rise, lowest group first.
`timescale 1ns/10ps
module pixel_port_multiplexer
   import pixel_port_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic video_control_clock,
   input wire logic pixel_dot_clock,
   input wire logic nibble_select_flag,
   input wire logic [31:0] pixel_bus,
   input wire logic [7:0] legacy_pixel,
   output logic [7:0] palette_address,
   output logic palette_address_valid,
   output logic mode_reserved
);

   typedef struct packed {
      logic [1:0] load_sync;
      logic [1:0] dot_sync;
      logic [1:0] flag_sync;
      logic [1:0][PIXEL_BUS_BITS-1:0] bus_sync;
      logic [1:0][LEGACY_BITS-1:0] legacy_sync;
      logic load_prev;
      logic dot_prev;
      mode_type mode;
      logic [PIXEL_BUS_BITS-1:0] held;
      logic [5:0] remaining;
      logic [4:0] index;
      logic [7:0] addr;
      logic valid;
      logic reserved;
   } mux_state_type;

   mux_state_type q;
   mux_state_type d;

   logic [7:0] format_reg;
   logic [7:0] control_reg;
   logic [7:0] page_reg;
   logic [31:0] status;
   logic [NIBBLE_BUS_BITS-1:0] nibble_bus;
   logic nibble_override;
   decode_type decoded;

   ahb_register_port u_regs (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .format_reg(format_reg),
      .control_reg(control_reg),
      .page_reg(page_reg),
      .status(status)
   );

   // Mode and pixels per load from the format code; bits 7:6 ignored
   function automatic decode_type decode_format(input logic [5:0] code, input logic nib);
      decode_type r;
      r.mode = MODE_RESERVED;
      r.per_load = 6'd0;
      if (nib) begin
         r.mode = MODE_NIBBLE;
         r.per_load = 6'd4;
      end else if (code == CODE_PASS) begin
         r.mode = MODE_PASS;
         r.per_load = 6'd1;
      end else if (code == CODE_NIBBLE) begin
         r.mode = MODE_NIBBLE;
         r.per_load = 6'd4;
      end else if (code[5:2] == CODE_PLANE1) begin
         r.mode = MODE_PLANE1;
         r.per_load = 6'd4 << code[1:0];
      end else if (code[5:2] == CODE_PLANE2) begin
         r.mode = MODE_PLANE2;
         r.per_load = 6'd2 << code[1:0];
      end else if (code[5:2] == CODE_PLANE4) begin
         r.mode = MODE_PLANE4;
         r.per_load = 6'd1 << code[1:0];
      end else if (code[5:2] == CODE_PLANE8) begin
         r.mode = MODE_PLANE8;
         r.per_load = 6'd1 << code[1:0];
      end
      return r;
   endfunction

   assign nibble_override = control_reg[NIBBLE_ENABLE_BIT] && !control_reg[SPLIT_SHIFT_BIT];
   assign decoded = decode_format(format_reg[FORMAT_CODE_BITS-1:0], nibble_override);

   // Nibble mode keeps one nibble of each byte, lowest byte first
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_nibble
         assign nibble_bus[gi*4 +: 4] = q.flag_sync[1] ?
            q.bus_sync[1][gi*8+4 +: 4] : q.bus_sync[1][gi*8 +: 4];
      end
   endgenerate

   always_comb begin
      logic [PIXEL_BUS_BITS-1:0] shifted;
      logic [4:0] amount;
      shifted = '0;
      amount = 5'd0;
      d = q;
      d.load_sync = {q.load_sync[0], video_control_clock};
      d.dot_sync = {q.dot_sync[0], pixel_dot_clock};
      d.flag_sync = {q.flag_sync[0], nibble_select_flag};
      d.bus_sync = {q.bus_sync[0], pixel_bus};
      d.legacy_sync = {q.legacy_sync[0], legacy_pixel};
      d.load_prev = q.load_sync[1];
      d.dot_prev = q.dot_sync[1];
      d.valid = 1'b0;

      case (q.mode)
         MODE_PLANE1: amount = q.index;
         MODE_PLANE2: amount = {q.index[3:0], 1'b0};
         MODE_PLANE4: amount = {q.index[2:0], 2'b00};
         MODE_NIBBLE: amount = {q.index[2:0], 2'b00};
         MODE_PLANE8: amount = {q.index[1:0], 3'b000};
         default: amount = 5'd0;
      endcase
      shifted = q.held >> amount;

      if (q.load_sync[1] && !q.load_prev) begin
         // Whole load and current format taken together
         d.mode = decoded.mode;
         d.remaining = decoded.per_load;
         d.index = 5'd0;
         d.reserved = (decoded.mode == MODE_RESERVED);
         if (decoded.mode == MODE_PASS) begin
            d.held = {24'h00_0000, q.legacy_sync[1]};
         end else if (decoded.mode == MODE_NIBBLE) begin
            d.held = {16'h0000, nibble_bus};
         end else begin
            d.held = q.bus_sync[1];
         end
      end else if (q.dot_sync[1] && !q.dot_prev && q.remaining != 6'd0) begin
         d.valid = 1'b1;
         d.index = q.index + 5'd1;
         d.remaining = q.remaining - 6'd1;
         case (q.mode)
            MODE_PLANE1: d.addr = {page_reg[7:1], shifted[0]};
            MODE_PLANE2: d.addr = {page_reg[7:2], shifted[1:0]};
            MODE_PLANE4: d.addr = {page_reg[7:4], shifted[3:0]};
            MODE_NIBBLE: d.addr = {page_reg[7:4], shifted[3:0]};
            default: d.addr = shifted[7:0];
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q.load_sync <= 2'b00;
         q.dot_sync <= 2'b00;
         q.flag_sync <= 2'b00;
         q.bus_sync <= '0;
         q.legacy_sync <= '0;
         q.load_prev <= 1'b0;
         q.dot_prev <= 1'b0;
         q.mode <= MODE_PASS;
         q.held <= 32'h0000_0000;
         q.remaining <= 6'd0;
         q.index <= 5'd0;
         q.addr <= 8'h00;
         q.valid <= 1'b0;
         q.reserved <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // Status word fields placed at their package positions
   always_comb begin
      status = 32'h0000_0000;
      status[STATUS_MODE_POS +: 3] = q.mode;
      status[STATUS_REMAIN_POS +: 6] = q.remaining;
      status[STATUS_INDEX_POS +: 5] = q.index;
   end
   assign palette_address = q.addr;
   assign palette_address_valid = q.valid;
   assign mode_reserved = q.reserved;

endmodule // pixel_port_multiplexer

// >>> pixel_port_monitor.sv
// Purpose: Port checker of the pixel port multiplexer.
// Assumes: One hclk domain, hresetn active low.
// Notes: Bound to the design from the bench top file.
`timescale 1ns/10ps
module pixel_port_monitor
   import pixel_port_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic pixel_dot_clock,
   input wire logic [7:0] palette_address,
   input wire logic palette_address_valid,
   input wire logic mode_reserved
);
   logic take;
   logic rd_q;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   assign take = hsel && hready && htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_q <= 1'b0;
      end else begin
         rd_q <= take && !hwrite;
      end
   end
   sequence fmt_wr_rd;
      (take && hwrite && haddr[11:0] == OFF_FORMAT) ##2
      (take && !hwrite && haddr[11:0] == OFF_FORMAT);
   endsequence
   chk_ready_high: assert property ($past(hresetn) |-> hreadyout)
      else $error("hreadyout low");
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("hresp not okay");
   chk_fmt_readback: assert property (fmt_wr_rd |=> hrdata[7:0] == $past(hwdata[7:0], 2))
      else $error("format readback wrong");
   chk_rdata_hold: assert property (!rd_q |-> $stable(hrdata))
      else $error("hrdata moved without read");
   chk_valid_pulse: assert property (palette_address_valid |=> !palette_address_valid)
      else $error("valid longer than one cycle");
   chk_valid_dot: assert property (palette_address_valid |-> $past(pixel_dot_clock, 3))
      else $error("pixel without dot clock");
   chk_addr_hold: assert property (!palette_address_valid |-> $stable(palette_address))
      else $error("address moved without valid");
   chk_reserved_quiet: assert property (mode_reserved |-> !palette_address_valid)
      else $error("pixel in reserved mode");
endmodule // pixel_port_monitor

// >>> frame_buffer_model.sv
// Purpose: Frame buffer side driving the pixel port pins.
// Assumes: Link clocks high for 8 hclk, low for 8 (dot clock: 8 + gap); 64 ns period at gap 0.
// Notes: Link clocks stand still between loads; released pins invert.
`timescale 1ns/10ps
module frame_buffer_model (
   input wire logic hclk,
   output logic video_control_clock,
   output logic pixel_dot_clock,
   output logic nibble_select_flag,
   output logic [31:0] pixel_bus,
   output logic [7:0] legacy_pixel
);
   initial begin
      video_control_clock = 1'b0;
      pixel_dot_clock = 1'b0;
      nibble_select_flag = 1'b0;
      pixel_bus = 32'h0000_0000;
      legacy_pixel = 8'h00;
   end
   task automatic wait_edges(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // One bus load, then dots; gap slows the dot clock
   task automatic send(input logic [31:0] w, input logic [7:0] l, input logic f,
         input int dots, gap);
      pixel_bus <= w;
      legacy_pixel <= l;
      nibble_select_flag <= f;
      wait_edges(8);
      video_control_clock <= 1'b1;
      wait_edges(8);
      video_control_clock <= 1'b0;
      pixel_bus <= ~w;
      legacy_pixel <= ~l;
      nibble_select_flag <= ~f;
      repeat (dots) begin
         wait_edges(8 + gap);
         pixel_dot_clock <= 1'b1;
         wait_edges(8);
         pixel_dot_clock <= 1'b0;
      end
      wait_edges(8);
   endtask
endmodule // frame_buffer_model

// >>> pixel_port_multiplexer_tb.sv
// Purpose: Self-checking bench of the pixel port multiplexer.
// Assumes: hclk 4 ns; link clocks 64 ns from the frame buffer model at gap 0, dots 76 and 84 ns at gaps 3 and 5.
// Notes: An integer model predicts every palette address.
`timescale 1ns/10ps
`define CHECK(what, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
   $display("BAD %s exp %0h got %0h", what, e, g); end end
module pixel_port_multiplexer_tb
   import pixel_port_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic video_control_clock, pixel_dot_clock, nibble_select_flag;
   logic palette_address_valid, mode_reserved;
   logic [31:0] haddr, hwdata, hrdata, pixel_bus, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] legacy_pixel, palette_address;
   logic [7:0] got[$];
   int exp_q[$];
   int bad_count, checks_done, c, t, pg;
   pixel_port_multiplexer dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .video_control_clock,
      .pixel_dot_clock, .nibble_select_flag, .pixel_bus, .legacy_pixel, .palette_address,
      .palette_address_valid, .mode_reserved);
   frame_buffer_model fb (.hclk, .video_control_clock, .pixel_dot_clock,
      .nibble_select_flag, .pixel_bus, .legacy_pixel);
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      if (palette_address_valid === 1'b1) got.push_back(palette_address);
   end
   task automatic ahb(input logic w, input logic [31:0] a, d);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   function automatic int model(input int c, t, pg, w, l, f);
      int b;
      int n;
      n = 1 << (c & 3);
      exp_q = {};
      if (c == 'h1f || (t & 'hc) == 8) begin
         for (int i = 0; i < 4; i++) exp_q.push_back(pg & 'hf0 | w >> (8 * i + 4 * f) & 15);
         return 0;
      end
      if (c == 'h2d) exp_q.push_back(l);
      case (c >> 2)
         4: b = 1;
         5: b = 2;
         6: b = 4;
         7: b = 8;
         default: b = 0;
      endcase
      n = n * (b == 1 ? 4 : b == 2 ? 2 : 1);
      for (int i = 0; i < n && b > 0; i++)
         exp_q.push_back(pg & ~((1 << b) - 1) & 255 | w >> (i * b) & ((1 << b) - 1));
      return c != 'h2d && b == 0;
   endfunction
   task automatic load(input int c, t, pg, gap);
      logic [31:0] w;
      logic [7:0] l;
      logic f;
      int res;
      w = $urandom;
      l = 8'($urandom);
      f = 1'($urandom);
      res = model(c, t, pg, w, l, f);
      got = {};
      fb.send(w, l, f, exp_q.size() + 1, gap);
      `CHECK("count", exp_q.size(), got.size())
      foreach (exp_q[i]) `CHECK("pixel", exp_q[i], got[i])
      `CHECK("reserved", res, mode_reserved)
   endtask
   task automatic report_and_stop;
      $display("checks %0d bad %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge hclk);
      bad_count++;
      report_and_stop;
   end
   initial begin
      {hresetn, hwrite, htrans, haddr, hwdata} = '0;
      hsel = 1'b1;
      hsize = HSIZE_WORD;
      void'($urandom(64));
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      ahb(0, OFF_FORMAT, 0);
      `CHECK("format", FORMAT_RESET, rd[7:0])
      ahb(0, 32'h0000_0040, 0);
      `CHECK("unmapped", 0, rd)
      load('h2d, 0, 0, 0);
      ahb(1, OFF_FORMAT, 'hde);
      ahb(0, OFF_FORMAT, 0);
      `CHECK("readback", 'hde, rd[7:0])
      load('h1e, 0, 0, 3);
      ahb(0, OFF_STATUS, 0);
      `CHECK("status", 4 << STATUS_INDEX_POS | int'(MODE_PLANE8) << STATUS_MODE_POS, rd)
      $display("reset and registers done");
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 19; i++) begin
            c = i < 16 ? 'h10 + i : i == 16 ? 'h2d : i == 17 ? 0 : 'h3f;
            t = p ? 8 | $urandom & 4 : 0;
            pg = $urandom & 255;
            ahb(1, OFF_FORMAT, $urandom & 'hc0 | c);
            ahb(1, OFF_CONTROL, t);
            ahb(1, OFF_PAGE, pg);
            load(c, t, pg, p * 5);
         end
         $display("mode pass %0d done", p);
      end
      ahb(1, OFF_FORMAT, 'h1e);
      ahb(1, OFF_CONTROL, 0);
      ahb(1, OFF_PAGE, 0);
      fork
         load('h1e, 0, 0, 0);
         begin
            repeat (24) @(posedge hclk);
            ahb(1, OFF_FORMAT, 'h10);
         end
      join
      load('h10, 0, 0, 0);
      $display("format change done");
      report_and_stop;
   end
endmodule // pixel_port_multiplexer_tb
bind pixel_port_multiplexer pixel_port_monitor mon (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .pixel_dot_clock,
   .palette_address, .palette_address_valid, .mode_reserved);
